// *** hw/bfbi_pkg.sv ***
// Shared constants and types of the burst flash bus interface.
package bfbi_pkg;
  localparam int ADDR_W        = 22;
  localparam int DATA_W        = 16;
  localparam int FIFO_DEPTH    = 32;
  localparam int MEM_AW        = 10;
  localparam int BOOT_SECT_LSB = 12;
  localparam int EDGE_SEL_BIT  = 17;
  localparam int SECT_W        = ADDR_W - BOOT_SECT_LSB;
  localparam logic [SECT_W-1:0] SECT_BOTTOM    = 10'h000;
  localparam logic [SECT_W-1:0] SECT_TOP       = 10'h3FF;
  localparam logic [ADDR_W-1:0] BANK_B_BASE    = 22'h08_0000;
  localparam logic [ADDR_W-1:0] BANK_C_BASE    = 22'h20_0000;
  localparam logic [ADDR_W-1:0] BANK_D_BASE    = 22'h38_0000;
  localparam logic [DATA_W-1:0] CMD_SET_CONFIG = 16'h00C0;
  localparam logic [1:0]        ACC_LOW        = 2'h0;
  localparam logic [1:0]        ACC_NORMAL     = 2'h1;
  localparam logic [1:0]        ACC_ELEVATED   = 2'h2;
  localparam logic [3:0]        INIT_WAIT_STD  = 4'h7;
  localparam logic [3:0]        INIT_WAIT_RED  = 4'h5;
  localparam logic [3:0]        BANKS_ALL      = 4'hF;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_WAIT  = 3'h2,
    ST_BURST = 3'h4
  } bfbi_state_type;
endpackage

// *** hw/bfbi_mem_if.sv ***
// Port between the bus interface and its word array.
`timescale 1ns/10ps
interface bfbi_mem_if #(
  parameter int AW = 10,
  parameter int DW = 16
);
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport host  (output we, output addr, output wdata, input rdata);
  modport array (input we, input addr, input wdata, output rdata);
endinterface

// *** hw/bfbi_mem.sv ***
// Word array with registered read data.
`timescale 1ns/10ps
module bfbi_mem #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  // Clock.
  input wire logic    sys_clk,
  // Array port.
  bfbi_mem_if.array   port
);
  logic [DW-1:0] words [0:(1<<AW)-1];
  logic [DW-1:0] readData;

  assign port.rdata = readData;

  always_ff @(posedge sys_clk) begin
    if (port.we) begin
      words[port.addr] <= port.wdata;
    end
    readData <= words[port.addr];
  end
endmodule

// *** hw/bfbi_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module bfbi_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Filling side.
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] slots [0:DEPTH-1];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [PW:0]      count;
  logic             doPush;
  logic             doPop;

  assign inReady  = (count != (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = slots[rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      slots[wrPtr] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= doPush ? PW'((wrPtr + 1'b1) % DEPTH) : wrPtr;
      rdPtr <= doPop ? PW'((rdPtr + 1'b1) % DEPTH) : rdPtr;
      count <= count + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end
endmodule

// *** hw/bfbi_top.sv ***
// Pin-level bus interface of a 16-bit burst flash: decode, burst engine, command latches.
`timescale 1ns/10ps
// Function
// - Take 22-bit word addresses, move 16-bit words over a shared two-way data bus.
// - Ready pin low while data not yet valid, high when valid.
// - Burst: each active clock edge after first word steps address; async ignores clock.
// - Address-valid low in burst mode latches burst start address.
// - Address-valid high means address inputs are ignored.
// - Write-protect low refuses program and erase in both outermost sectors.
// - Accelerate elevated gives unlock bypass; accelerate low locks all sectors.
// - Async read captures address on address-valid rise, then drives that word.
// - Each bank stays readable until command register contents change.
// - Power-up and hardware reset return to async array reads.
// - Command register is internal latches, unaddressed, feeding the state machine.
// - Rising clock edge is active unless reconfigured.
// - Load start address: chip enable low, write-enable high, strobe with clock edge.
// - Enables low, strobe high: each active edge presents next burst word.
// - Reset pin low ends burst at once and floats the data pins.
// - New address-valid pulse with chip enable low restarts burst at new address.
// - Reduced handshake grades shorten initial access at even addresses.
// - After configuration command, only synchronous burst reads are accepted.
module bfbi_top
  import bfbi_pkg::*;
#(
  parameter int   FIFO_W     = 32,
  parameter int   FIFO_D     = FIFO_DEPTH,
  parameter int   ARRAY_AW   = MEM_AW,
  parameter logic REDUCED_HS = 1'b1
) (
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // Bus control pins.
  input  wire logic              chipEnableN,
  input  wire logic              outputEnableN,
  input  wire logic              writeEnableN,
  input  wire logic              addressValidStrobeN,
  input  wire logic              resetPinN,
  input  wire logic              linkClk,
  input  wire logic              writeProtectN,
  input  wire logic [1:0]        programAccelerate,
  // Address and data pins.
  input  wire logic [ADDR_W-1:0] wordAddressBus,
  input  wire logic [DATA_W-1:0] dataBusIn,
  output logic      [DATA_W-1:0] dataBusOut,
  output logic                   dataBusOe,
  // Ready pin.
  output logic                   ready,
  output logic                   readyOe,
  // Status levels and event pulses.
  output logic                   syncMode,
  output logic                   unlockBypass,
  output logic      [3:0]        bankReadEnable,
  output logic                   writeRefused,
  output logic                   programRefused
);
  localparam int PIN_W = 8 + 2 + ADDR_W + DATA_W;

  logic [PIN_W-1:0]  pinMeta;
  logic [PIN_W-1:0]  pinSync;
  logic              ceS, oeS, weS, avdS, rstS, clkS, wpS;
  logic [1:0]        accS;
  logic [ADDR_W-1:0] addrS;
  logic [DATA_W-1:0] dinS;
  logic              clkPrev, wePrev;
  logic              edgeFalling;
  logic              activeEdge;
  bfbi_state_type    state, next_state;
  logic [ADDR_W-1:0] burstAddr, next_burstAddr;
  logic [ADDR_W-1:0] asyncAddr;
  logic [3:0]        waitCnt, next_waitCnt;
  logic              enterBurst;
  logic [ADDR_W-1:0] cmdAddr;
  logic [DATA_W-1:0] cmdData;
  logic              cmdArmed;
  logic              cmdCommit;
  logic              loadCond, advance, restart;
  logic [3:0]        initWait;
  logic              readBusy;
  logic              fifoInReady, fifoOutValid, drainReady;
  logic [FIFO_W+ADDR_W+DATA_W-FIFO_W-1:0] fifoOut;
  logic [ADDR_W-1:0] drainAddr;
  logic [DATA_W-1:0] drainData;
  logic              outerSector, locked, drainDo;
  logic [1:0]        cmdBank;

  bfbi_mem_if #(.AW(ARRAY_AW), .DW(DATA_W)) memPort ();

  // Every pin crosses two flip-flops before any logic looks at it.
  always_ff @(posedge sys_clk) begin
    pinMeta <= {chipEnableN, outputEnableN, writeEnableN, addressValidStrobeN, resetPinN, linkClk,
                writeProtectN, 1'b0, programAccelerate, wordAddressBus, dataBusIn};
    pinSync <= pinMeta;
  end
  assign {ceS, oeS, weS, avdS, rstS, clkS, wpS} = pinSync[PIN_W-1:PIN_W-7];
  assign accS  = pinSync[ADDR_W+DATA_W+1:ADDR_W+DATA_W];
  assign addrS = pinSync[ADDR_W+DATA_W-1:DATA_W];
  assign dinS  = pinSync[DATA_W-1:0];

  assign activeEdge = edgeFalling ? (clkPrev && !clkS) : (!clkPrev && clkS);
  assign readBusy   = !ceS && weS;
  assign loadCond   = syncMode && rstS && readBusy && !avdS && activeEdge;
  assign advance    = (state == ST_BURST) && rstS && readBusy && !oeS && avdS && activeEdge;
  assign restart    = (state != ST_IDLE) && loadCond;
  assign initWait   = (REDUCED_HS && !addrS[0]) ? INIT_WAIT_RED : INIT_WAIT_STD;
  assign cmdCommit  = weS && !wePrev && cmdArmed;
  assign cmdBank    = (cmdAddr < BANK_B_BASE) ? 2'h0 : (cmdAddr < BANK_C_BASE) ? 2'h1 :
                      (cmdAddr < BANK_D_BASE) ? 2'h2 : 2'h3;

  // Burst engine; the link clock only matters in synchronous mode.
  always_comb begin
    next_state     = state;
    next_burstAddr = burstAddr;
    next_waitCnt   = waitCnt;
    if (!rstS || ceS || !syncMode) begin
      next_state = ST_IDLE;
    end else if (loadCond) begin
      next_state     = ST_WAIT;
      next_burstAddr = addrS;
      next_waitCnt   = initWait;
    end else begin
      case (state)
        ST_WAIT: begin
          if (activeEdge) begin
            next_waitCnt = waitCnt - 4'h1;
            if (waitCnt == 4'h1) begin
              next_state = ST_BURST;
            end
          end
        end
        ST_BURST: begin
          if (advance) begin
            next_burstAddr = burstAddr + 22'h00_0001;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state      <= ST_IDLE;
      burstAddr  <= '0;
      waitCnt    <= '0;
      enterBurst <= 1'b0;
      clkPrev    <= 1'b0;
      wePrev     <= 1'b1;
    end else begin
      state      <= next_state;
      burstAddr  <= next_burstAddr;
      waitCnt    <= next_waitCnt;
      enterBurst <= (next_state == ST_BURST) && (state != ST_BURST);
      clkPrev    <= clkS;
      wePrev     <= weS;
    end
  end

  // Async reads follow the address while the strobe is low and keep it from its rise.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      asyncAddr <= '0;
    end else if (!syncMode && readBusy && !avdS) begin
      asyncAddr <= addrS;
    end
  end

  // Command latches: address and data held through the write pulse, committed on its end.
  always_ff @(posedge sys_clk) begin
    if (reset || !rstS) begin
      cmdArmed <= 1'b0;
      cmdAddr  <= '0;
      cmdData  <= '0;
    end else if (!ceS && !weS && oeS && !avdS) begin
      cmdArmed <= 1'b1;
      cmdAddr  <= addrS;
      cmdData  <= dinS;
    end else if (cmdCommit) begin
      cmdArmed <= 1'b0;
    end
  end

  // Mode, clock polarity and bank read enables.
  always_ff @(posedge sys_clk) begin
    if (reset || !rstS) begin
      syncMode       <= 1'b0;
      edgeFalling    <= 1'b0;
      bankReadEnable <= BANKS_ALL;
    end else begin
      if (cmdCommit && cmdData == CMD_SET_CONFIG) begin
        syncMode    <= 1'b1;
        edgeFalling <= cmdAddr[EDGE_SEL_BIT];
      end
      if (cmdCommit) begin
        bankReadEnable[cmdBank] <= 1'b0;
      end else if (!fifoOutValid) begin
        bankReadEnable <= BANKS_ALL;
      end
    end
  end

  // Program queue; drained into the array only while no read cycle is in progress.
  assign drainReady = !readBusy;
  bfbi_fifo #(.WIDTH(ADDR_W+DATA_W), .DEPTH(FIFO_D)) u_queue (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .inValid  (cmdCommit && cmdData != CMD_SET_CONFIG),
    .inReady  (fifoInReady),
    .inData   ({cmdAddr, cmdData}),
    .outValid (fifoOutValid),
    .outReady (drainReady),
    .outData  (fifoOut)
  );
  assign {drainAddr, drainData} = fifoOut;
  assign outerSector = (drainAddr[ADDR_W-1:BOOT_SECT_LSB] == SECT_BOTTOM) ||
                       (drainAddr[ADDR_W-1:BOOT_SECT_LSB] == SECT_TOP);
  assign locked      = (accS == ACC_LOW) || (!wpS && outerSector);
  assign drainDo     = fifoOutValid && drainReady;

  assign memPort.we    = drainDo && !locked;
  assign memPort.addr  = drainDo ? drainAddr[ARRAY_AW-1:0] :
                         (syncMode ? burstAddr[ARRAY_AW-1:0] : asyncAddr[ARRAY_AW-1:0]);
  assign memPort.wdata = drainData;

  bfbi_mem #(.AW(ARRAY_AW), .DW(DATA_W)) u_array (
    .sys_clk (sys_clk),
    .port    (memPort)
  );

  // Pin outputs, all registered.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dataBusOut     <= '0;
      dataBusOe      <= 1'b0;
      ready          <= 1'b1;
      readyOe        <= 1'b0;
      unlockBypass   <= 1'b0;
      writeRefused   <= 1'b0;
      programRefused <= 1'b0;
    end else begin
      dataBusOut     <= memPort.rdata;
      dataBusOe      <= rstS && readBusy && !oeS && (!syncMode || next_state == ST_BURST);
      ready          <= (state != ST_WAIT) && !enterBurst;
      readyOe        <= rstS && !ceS;
      unlockBypass   <= (accS == ACC_ELEVATED);
      writeRefused   <= cmdCommit && cmdData != CMD_SET_CONFIG && !fifoInReady;
      programRefused <= drainDo && locked;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_load;
    loadCond && !restart;
  endsequence
  sequence s_async_latch;
    !syncMode && readBusy && $rose(avdS);
  endsequence

  property p_reset_floats;
    !rstS |=> state == ST_IDLE && !dataBusOe && !syncMode && !edgeFalling;
  endproperty
  a_reset_floats: assert property (p_reset_floats) else $error("reset pin did not float bus");
  property p_standby;
    ceS |=> !dataBusOe ##1 state == ST_IDLE;
  endproperty
  a_standby: assert property (p_standby) else $error("standby left bus driven");
  property p_wait_ready;
    state == ST_WAIT |=> !ready;
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("ready high during latency");
  property p_latch;
    s_load |=> state == ST_WAIT && burstAddr == $past(addrS);
  endproperty
  a_latch: assert property (p_latch) else $error("burst start address not latched");
  property p_ignore;
    avdS && !advance |=> $stable(burstAddr);
  endproperty
  a_ignore: assert property (p_ignore) else $error("address moved with strobe high");
  property p_advance;
    advance && !ceS |=> burstAddr == $past(burstAddr) + 22'h00_0001;
  endproperty
  a_advance: assert property (p_advance) else $error("burst address did not step");
  property p_async_clock;
    !syncMode |=> state == ST_IDLE;
  endproperty
  a_async_clock: assert property (p_async_clock) else $error("clock used in async mode");
  property p_restart;
    restart |=> state == ST_WAIT;
  endproperty
  a_restart: assert property (p_restart) else $error("new strobe did not restart burst");
  property p_latency;
    loadCond && REDUCED_HS && !addrS[0] |=> waitCnt == INIT_WAIT_RED;
  endproperty
  a_latency: assert property (p_latency) else $error("even address latency wrong");
  property p_async_hold;
    s_async_latch ##1 (avdS && !ceS) |-> $stable(asyncAddr);
  endproperty
  a_async_hold: assert property (p_async_hold) else $error("async address not held");
  property p_protect;
    drainDo && locked |-> !memPort.we ##1 programRefused;
  endproperty
  a_protect: assert property (p_protect) else $error("protected program not refused");
  property p_config;
    cmdCommit && cmdData == CMD_SET_CONFIG && rstS |=> syncMode;
  endproperty
  a_config: assert property (p_config) else $error("configuration command ignored");
  property p_bank;
    cmdCommit && rstS |=> !bankReadEnable[$past(cmdBank)];
  endproperty
  a_bank: assert property (p_bank) else $error("bank read enable not cleared");
endmodule

// *** test/bfbi_host_model.sv ***
// Host controller model that drives the flash pins.
`timescale 1ns/10ps
module bfbi_host_model
  import bfbi_pkg::*;
(
  // Clock.
  input  wire logic              sys_clk,
  // Control pins.
  output logic                   chipEnableN,
  output logic                   outputEnableN,
  output logic                   writeEnableN,
  output logic                   addressValidStrobeN,
  output logic                   linkClk,
  // Address and data pins.
  output logic      [ADDR_W-1:0] wordAddressBus,
  output logic      [DATA_W-1:0] dataBusIn,
  input  wire logic [DATA_W-1:0] dataBusOut,
  input  wire logic              dataBusOe
);
  logic              hostDrive;
  logic [DATA_W-1:0] hostData;
  logic [DATA_W-1:0] floatPat  = 16'h0000;

  // A released bus shows a changing pattern, never the last value driven.
  always @(posedge sys_clk) begin
    floatPat <= floatPat + 16'h3B1D;
  end
  assign dataBusIn = dataBusOe ? dataBusOut : (hostDrive ? hostData : floatPat);

  initial begin
    chipEnableN         = 1'b1;
    outputEnableN       = 1'b1;
    writeEnableN        = 1'b1;
    addressValidStrobeN = 1'b1;
    linkClk             = 1'b0;
    wordAddressBus      = 22'h00_0000;
    hostDrive           = 1'b0;
    hostData            = 16'h0000;
  end

  // Waits n rising edges, then half a cycle so outputs have settled.
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic pins(input logic ce, input logic oe, input logic we, input logic avd);
    @(posedge sys_clk);
    chipEnableN         <= ce;
    outputEnableN       <= oe;
    writeEnableN        <= we;
    addressValidStrobeN <= avd;
  endtask

  task automatic idle;
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    hold(3);
  endtask

  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    wordAddressBus <= a;
    hostData       <= d;
    hostDrive      <= 1'b1;
    hold(4);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    hold(3);
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    hostDrive <= 1'b0;
    hold(3);
  endtask

  task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic oe);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    wordAddressBus <= a;
    hold(4);
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    hold(5);
    d  = dataBusIn;
    oe = dataBusOe;
    idle();
  endtask

  // One full link clock period of eight system cycles, rising first.
  task automatic clock_edge;
    @(posedge sys_clk);
    linkClk <= 1'b1;
    hold(3);
    @(posedge sys_clk);
    linkClk <= 1'b0;
    hold(3);
  endtask

  task automatic burst_load(input logic [ADDR_W-1:0] a);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    wordAddressBus <= a;
    hold(3);
    clock_edge();
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    wordAddressBus <= ~a;
    hold(3);
  endtask
endmodule

// *** test/bfbi_bench.sv ***
// Self-checking bench of the burst flash bus interface.
`timescale 1ns/10ps
module bfbi_bench
  import bfbi_pkg::*;
;
  logic              sys_clk;
  logic              reset;
  logic              resetPinN;
  logic              writeProtectN;
  logic [1:0]        programAccelerate;
  wire               chipEnableN;
  wire               outputEnableN;
  wire               writeEnableN;
  wire               addressValidStrobeN;
  wire               linkClk;
  wire  [ADDR_W-1:0] wordAddressBus;
  wire  [DATA_W-1:0] dataBusIn;
  logic [DATA_W-1:0] dataBusOut;
  logic              dataBusOe;
  logic              ready;
  logic              readyOe;
  logic              syncMode;
  logic              unlockBypass;
  logic [3:0]        bankReadEnable;
  logic              writeRefused;
  logic              programRefused;
  int                mismatches = 0;
  int                num_checks = 0;
  int                refusedCnt = 0;
  int                lostCnt    = 0;
  logic              bankBClr   = 1'b0;

  bfbi_top dut (.sys_clk(sys_clk), .reset(reset), .chipEnableN(chipEnableN),
    .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
    .addressValidStrobeN(addressValidStrobeN), .resetPinN(resetPinN), .linkClk(linkClk),
    .writeProtectN(writeProtectN), .programAccelerate(programAccelerate),
    .wordAddressBus(wordAddressBus), .dataBusIn(dataBusIn), .dataBusOut(dataBusOut),
    .dataBusOe(dataBusOe), .ready(ready), .readyOe(readyOe), .syncMode(syncMode),
    .unlockBypass(unlockBypass), .bankReadEnable(bankReadEnable),
    .writeRefused(writeRefused), .programRefused(programRefused));

  bfbi_host_model host (.sys_clk(sys_clk), .chipEnableN(chipEnableN),
    .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
    .addressValidStrobeN(addressValidStrobeN), .linkClk(linkClk),
    .wordAddressBus(wordAddressBus), .dataBusIn(dataBusIn), .dataBusOut(dataBusOut),
    .dataBusOe(dataBusOe));

  always @(posedge sys_clk) begin
    if (programRefused === 1'b1) begin
      refusedCnt <= refusedCnt + 1;
    end
    if (writeRefused === 1'b1) begin
      lostCnt <= lostCnt + 1;
    end
    if (bankReadEnable[1] === 1'b0) begin
      bankBClr <= 1'b1;
    end
  end

  function automatic logic [DATA_W-1:0] word(input int i);
    return 16'h5A00 + 16'(i);
  endfunction

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic test_reset;
    check(16'(dataBusOe), 16'h0000, "bus drive after reset");
    check(16'(syncMode), 16'h0000, "mode after reset");
    check(16'(bankReadEnable), 16'(BANKS_ALL), "banks after reset");
    $display("test reset done");
  endtask

  task automatic test_write_read;
    logic [DATA_W-1:0] got;
    logic              oe;
    for (int i = 0; i < 4; i++) begin
      host.write(BANK_B_BASE + 22'(i), word(i));
    end
    for (int n = 0; n < 100 && bankReadEnable !== BANKS_ALL; n++) begin
      host.hold(1);
    end
    check(16'(bankBClr), 16'h0001, "bank held during write");
    check(16'(bankReadEnable), 16'(BANKS_ALL), "banks after drain");
    for (int i = 3; i >= 0; i--) begin
      host.read(BANK_B_BASE + 22'(i), got, oe);
      check(got, word(i), "async read word");
      check(16'(oe), 16'h0001, "async read drive");
    end
    check(16'(dataBusOe), 16'h0000, "standby drive");
    $display("test write read done");
  endtask

  task automatic write_expect(input logic [ADDR_W-1:0] a, input int exp, input int r0);
    host.write(a, 16'h1111);
    host.hold(40);
    check(16'(refusedCnt - r0), 16'(exp), "refusal count");
  endtask

  task automatic test_protect;
    int r0;
    r0 = refusedCnt;
    @(posedge sys_clk);
    writeProtectN <= 1'b0;
    write_expect({SECT_TOP, 12'h010}, 1, r0);
    write_expect({SECT_BOTTOM, 12'h010}, 2, r0);
    write_expect(BANK_B_BASE + 22'h00_0130, 2, r0);
    @(posedge sys_clk);
    writeProtectN     <= 1'b1;
    programAccelerate <= ACC_LOW;
    write_expect(BANK_B_BASE + 22'h00_0131, 3, r0);
    @(posedge sys_clk);
    programAccelerate <= ACC_ELEVATED;
    host.hold(5);
    check(16'(unlockBypass), 16'h0001, "bypass on elevated");
    @(posedge sys_clk);
    programAccelerate <= ACC_NORMAL;
    host.hold(5);
    check(16'(unlockBypass), 16'h0000, "bypass on normal");
    $display("test protect done");
  endtask

  task automatic test_config;
    logic [DATA_W-1:0] got;
    logic              oe;
    host.write(22'h00_0000, CMD_SET_CONFIG);
    host.hold(8);
    check(16'(syncMode), 16'h0001, "sync after config");
    host.read(BANK_B_BASE, got, oe);
    check(16'(oe), 16'h0000, "async read in sync mode");
    $display("test config done");
  endtask

  task automatic test_burst(input int first, input int steps);
    int edges;
    host.burst_load(BANK_B_BASE + 22'(first));
    check(16'(ready), 16'h0000, "ready during latency");
    check(16'(readyOe), 16'h0001, "ready driven");
    edges = 0;
    while (ready !== 1'b1 && edges < 12) begin
      host.clock_edge();
      edges++;
    end
    check(16'(edges), 16'(first[0] ? INIT_WAIT_STD : INIT_WAIT_RED), "initial latency edges");
    check(dataBusOut, word(first), "first burst word");
    for (int k = 1; k <= steps; k++) begin
      host.clock_edge();
      check(dataBusOut, word(first + k), "next burst word");
    end
    $display("test burst done");
  endtask

  task automatic test_hw_reset;
    logic [DATA_W-1:0] got;
    logic              oe;
    @(posedge sys_clk);
    resetPinN <= 1'b0;
    host.hold(5);
    check(16'(dataBusOe), 16'h0000, "bus float on reset pin");
    check(16'(syncMode), 16'h0000, "mode on reset pin");
    @(posedge sys_clk);
    resetPinN <= 1'b1;
    host.idle();
    host.read(BANK_B_BASE + 22'h00_0003, got, oe);
    check(got, word(3), "async read after reset pin");
    check(16'(lostCnt), 16'h0000, "write lost with queue not full");
    $display("test hardware reset done");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    #1_000_000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    reset             <= 1'b1;
    resetPinN         <= 1'b1;
    writeProtectN     <= 1'b1;
    programAccelerate <= ACC_NORMAL;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    host.hold(3);
    test_reset();
    test_write_read();
    test_protect();
    test_config();
    test_burst(0, 3);
    test_burst(1, 2);
    test_hw_reset();
    give_verdict();
  end
endmodule
